// File: include/cod_pkg.sv
// shared types, constants and opcode decoder for the op-decode slice
`default_nettype none
package cod_pkg;
    // ===========================================================
    // widths and fixed addresses
    // ===========================================================
    localparam int HI_W = 6;
    localparam int LO_W = 8;
    localparam int ADDR_W = HI_W + LO_W;
    localparam logic [ADDR_W-1:0] RESET_VECTOR = 14'h3ffd;
    localparam logic [ADDR_W-1:0] XPTR_ADDR = 14'h000f;
    localparam logic [ADDR_W-1:0] XDATA_ADDR = 14'h000e;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] XPTR_RST = 8'h00;
    localparam int TNY_W = 4;
    localparam int SRT_W = 5;

    // ===========================================================
    // opcodes
    // ===========================================================
    localparam logic [7:0] OP_ADC_IMM = 8'ha9;
    localparam logic [7:0] OP_ADC_DIR = 8'hb9;
    localparam logic [7:0] OP_ADD_IMM = 8'hab;
    localparam logic [7:0] OP_ADD_DIR = 8'hbb;
    localparam logic [7:0] OP_LSLA = 8'h48;
    localparam logic [7:0] OP_BRA = 8'h30;
    localparam logic [7:0] OP_BCC = 8'h34;
    localparam logic [7:0] OP_BCS = 8'h35;
    localparam logic [7:0] OP_BNE = 8'h36;
    localparam logic [7:0] OP_BEQ = 8'h37;
    localparam logic [7:0] OP_BGND = 8'hbf;
    localparam logic [7:0] OP_JMP = 8'hbc;
    localparam logic [7:0] OP_WAIT = 8'haf;
    localparam logic [7:0] OP_STOP = 8'hae;
    localparam logic [3:0] OPH_ADD_TNY = 4'h6;
    localparam logic [3:0] OPH_BITOP = 4'h1;
    localparam logic [2:0] OPH_LDA_SRT = 3'h6;
    localparam logic [2:0] OPH_STA_SRT = 3'h7;

    // ===========================================================
    // minimum cycle counts per instruction class
    // ===========================================================
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_IMM = 3'h2;
    localparam logic [2:0] CYC_SRT = 3'h2;
    localparam logic [2:0] CYC_MEM = 3'h3;
    localparam logic [2:0] CYC_BR = 3'h3;
    localparam logic [2:0] CYC_EXT = 3'h4;
    localparam logic [2:0] CYC_BIT = 3'h5;

    // ===========================================================
    // types
    // ===========================================================
    typedef struct packed {
        logic [HI_W-1:0] upper;
        logic [LO_W-1:0] lower;
    } cod_ptr_s;

    typedef struct packed {
        logic z;
        logic c;
    } cod_flags_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } cod_mreq_s;

    typedef enum logic [3:0] {
        K_NOP, K_ALU, K_LDA, K_STA, K_BR, K_JMP, K_BSET, K_BCLR, K_WAIT, K_STOP, K_BGND
    } cod_kind_e;

    typedef enum logic [2:0] {
        AM_INH, AM_IMM, AM_DIR, AM_TNY, AM_SRT, AM_EXT, AM_REL
    } cod_amode_e;

    typedef enum logic [1:0] {ALU_ADD, ALU_ADC, ALU_LSL} cod_alu_e;

    typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP, MODE_HALT} cod_mode_e;

    typedef struct packed {
        cod_kind_e kind;
        cod_amode_e amode;
        cod_alu_e alu;
        logic [2:0] cycles;
    } cod_dec_s;

    function automatic cod_dec_s cod_decode(input logic [7:0] op);
        cod_dec_s d;
        d = '{kind: K_NOP, amode: AM_INH, alu: ALU_ADD, cycles: CYC_ONE};
        if (op[7:4] == OPH_ADD_TNY) begin
            d = '{kind: K_ALU, amode: AM_TNY, alu: ALU_ADD, cycles: CYC_MEM};
        end else if (op[7:4] == OPH_BITOP) begin
            d = '{kind: (op[0] ? K_BCLR : K_BSET), amode: AM_DIR, alu: ALU_ADD, cycles: CYC_BIT};
        end else if (op[7:5] == OPH_LDA_SRT) begin
            d = '{kind: K_LDA, amode: AM_SRT, alu: ALU_ADD, cycles: CYC_SRT};
        end else if (op[7:5] == OPH_STA_SRT) begin
            d = '{kind: K_STA, amode: AM_SRT, alu: ALU_ADD, cycles: CYC_SRT};
        end else begin
            case (op)
                OP_ADD_IMM: d = '{kind: K_ALU, amode: AM_IMM, alu: ALU_ADD, cycles: CYC_IMM};
                OP_ADD_DIR: d = '{kind: K_ALU, amode: AM_DIR, alu: ALU_ADD, cycles: CYC_MEM};
                OP_ADC_IMM: d = '{kind: K_ALU, amode: AM_IMM, alu: ALU_ADC, cycles: CYC_IMM};
                OP_ADC_DIR: d = '{kind: K_ALU, amode: AM_DIR, alu: ALU_ADC, cycles: CYC_MEM};
                OP_LSLA: d = '{kind: K_ALU, amode: AM_INH, alu: ALU_LSL, cycles: CYC_ONE};
                OP_BRA, OP_BCC, OP_BCS, OP_BNE, OP_BEQ:
                    d = '{kind: K_BR, amode: AM_REL, alu: ALU_ADD, cycles: CYC_BR};
                OP_JMP: d = '{kind: K_JMP, amode: AM_EXT, alu: ALU_ADD, cycles: CYC_EXT};
                OP_WAIT: d = '{kind: K_WAIT, amode: AM_INH, alu: ALU_ADD, cycles: CYC_ONE};
                OP_STOP: d = '{kind: K_STOP, amode: AM_INH, alu: ALU_ADD, cycles: CYC_ONE};
                OP_BGND: d = '{kind: K_BGND, amode: AM_INH, alu: ALU_ADD, cycles: CYC_ONE};
                default: d = '{kind: K_NOP, amode: AM_INH, alu: ALU_ADD, cycles: CYC_ONE};
            endcase
        end
        return d;
    endfunction
endpackage
`default_nettype wire

// File: logic/cod_alu.sv
// accumulator adder and shifter with flag generation
`default_nettype none
module cod_alu import cod_pkg::*; (
    input wire cod_alu_e i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_cin,
    output logic [7:0] o_res,
    output cod_flags_s o_flags
);
    logic [8:0] sum;

    always_comb begin
        sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, (i_op == ALU_ADC) & i_cin};
        case (i_op)
            // the shift takes its own path, not the adder; result and flags equal those of adding acc to itself
            ALU_LSL: begin
                o_res = {i_a[6:0], 1'b0};
                o_flags.c = i_a[7];
            end
            default: begin
                o_res = sum[7:0];
                o_flags.c = sum[8];
            end
        endcase
        o_flags.z = (o_res == 8'h00);
    end
endmodule // cod_alu
`default_nettype wire

// File: logic/cod_core.sv
// decode and control slice: fetch, operand addressing, add ops, low-power and halt
`default_nettype none
module cod_core import cod_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_rdata,
    input wire logic i_wake_evt,
    input wire logic i_halt_req,
    input wire logic i_resume,
    output var cod_mreq_s o_mreq,
    output logic [7:0] o_acc,
    output cod_flags_s o_flags,
    output cod_ptr_s o_fetch_pointer,
    output cod_ptr_s o_saved_fetch_pointer,
    output logic o_core_clk_en,
    output var cod_mode_e o_mode
);
    // ===========================================================
    // state
    // ===========================================================
    typedef enum logic [3:0] {
        ST_FETCH, ST_OPND, ST_EXTLO, ST_MEM, ST_WB, ST_PAD, ST_WAIT, ST_STOP, ST_HALT
    } cod_state_e;

    cod_state_e st_r, st_nxt;
    cod_ptr_s pc_r, pc_nxt, spc_r, spc_nxt;
    cod_dec_s dec_r, dec_nxt, d;
    cod_flags_s flags_r, flags_nxt, alu_flags;
    logic [7:0] acc_r, acc_nxt, op_r, op_nxt, mdata_r, mdata_nxt, x_r, x_nxt, alu_res;
    logic [ADDR_W-1:0] ea_r, ea_nxt, pc_inc;
    logic [HI_W-1:0] ext_hi_r, ext_hi_nxt;
    logic [2:0] cnt_r, cnt_nxt, need;
    cod_alu_e alu_op;
    cod_state_e fin;
    logic taken;

    // pointer cell is shadowed inside the core so redirection costs no bus cycle;
    // only core writes to the cell are seen
    function automatic logic [ADDR_W-1:0] redirect(input logic [ADDR_W-1:0] ea, input logic [7:0] x);
        return (ea == XDATA_ADDR) ? {{HI_W{1'b0}}, x} : ea;
    endfunction

    assign d = cod_decode(i_rdata);
    assign alu_op = (st_r == ST_FETCH) ? d.alu : dec_r.alu;
    assign pc_inc = pc_r + 14'h0001;

    cod_alu u_alu (
        .i_op(alu_op),
        .i_a(acc_r),
        .i_b(i_rdata),
        .i_cin(flags_r.c),
        .o_res(alu_res),
        .o_flags(alu_flags)
    );

    // ===========================================================
    // sequencer
    // ===========================================================
    always_comb begin
        st_nxt = st_r;
        pc_nxt = pc_r;
        spc_nxt = spc_r;
        dec_nxt = dec_r;
        flags_nxt = flags_r;
        acc_nxt = acc_r;
        op_nxt = op_r;
        mdata_nxt = mdata_r;
        ea_nxt = ea_r;
        ext_hi_nxt = ext_hi_r;
        o_mreq = '{addr: pc_r, wdata: acc_r, we: 1'b0, re: 1'b0};
        // short instructions are padded up to their documented cycle count
        cnt_nxt = (st_r == ST_FETCH) ? CYC_ONE : cnt_r + 3'h1;
        need = (st_r == ST_FETCH) ? d.cycles : dec_r.cycles;
        fin = (cnt_nxt >= need) ? ST_FETCH : ST_PAD;
        case (op_r)
            OP_BCC: taken = !flags_r.c;
            OP_BCS: taken = flags_r.c;
            OP_BNE: taken = !flags_r.z;
            OP_BEQ: taken = flags_r.z;
            default: taken = 1'b1;
        endcase
        case (st_r)
            ST_FETCH: begin
                if (i_halt_req) begin
                    spc_nxt = pc_r;
                    st_nxt = ST_HALT;
                end else begin
                    o_mreq.re = 1'b1;
                    op_nxt = i_rdata;
                    dec_nxt = d;
                    pc_nxt = pc_inc;
                    case (d.amode)
                        AM_IMM, AM_DIR, AM_EXT, AM_REL: st_nxt = ST_OPND;
                        AM_TNY: begin
                            ea_nxt = redirect({{(ADDR_W-TNY_W){1'b0}}, i_rdata[TNY_W-1:0]}, x_r);
                            st_nxt = ST_MEM;
                        end
                        AM_SRT: begin
                            ea_nxt = redirect({{(ADDR_W-SRT_W){1'b0}}, i_rdata[SRT_W-1:0]}, x_r);
                            st_nxt = ST_MEM;
                        end
                        default: begin
                            st_nxt = fin;
                            case (d.kind)
                                K_ALU: begin
                                    acc_nxt = alu_res;
                                    flags_nxt = alu_flags;
                                end
                                K_WAIT: st_nxt = ST_WAIT;
                                K_STOP: st_nxt = ST_STOP;
                                K_BGND: begin
                                    spc_nxt = pc_inc;
                                    st_nxt = ST_HALT;
                                end
                                default: st_nxt = fin;
                            endcase
                        end
                    endcase
                end
            end
            ST_OPND: begin
                o_mreq.re = 1'b1;
                pc_nxt = pc_inc;
                st_nxt = fin;
                case (dec_r.amode)
                    AM_IMM: begin
                        acc_nxt = alu_res;
                        flags_nxt = alu_flags;
                    end
                    AM_DIR: begin
                        ea_nxt = redirect({{HI_W{1'b0}}, i_rdata}, x_r);
                        st_nxt = ST_MEM;
                    end
                    AM_EXT: begin
                        ext_hi_nxt = i_rdata[HI_W-1:0];
                        st_nxt = ST_EXTLO;
                    end
                    default: begin
                        if (taken) begin
                            pc_nxt = pc_inc + {{HI_W{i_rdata[7]}}, i_rdata};
                        end
                    end
                endcase
            end
            ST_EXTLO: begin
                o_mreq.re = 1'b1;
                pc_nxt = '{upper: ext_hi_r, lower: i_rdata};
                st_nxt = fin;
            end
            ST_MEM: begin
                o_mreq.addr = ea_r;
                o_mreq.re = (dec_r.kind != K_STA);
                o_mreq.we = (dec_r.kind == K_STA);
                st_nxt = fin;
                case (dec_r.kind)
                    K_ALU: begin
                        acc_nxt = alu_res;
                        flags_nxt = alu_flags;
                    end
                    K_LDA: begin
                        acc_nxt = i_rdata;
                        flags_nxt.z = (i_rdata == 8'h00);
                    end
                    K_BSET, K_BCLR: begin
                        mdata_nxt = i_rdata;
                        mdata_nxt[op_r[3:1]] = (dec_r.kind == K_BSET);
                        st_nxt = ST_WB;
                    end
                    default: st_nxt = fin;
                endcase
            end
            ST_WB: begin
                o_mreq = '{addr: ea_r, wdata: mdata_r, we: 1'b1, re: 1'b0};
                st_nxt = fin;
            end
            ST_PAD: st_nxt = fin;
            // pc already points past the low-power opcode, so wake just refetches
            ST_WAIT, ST_STOP: begin
                if (i_wake_evt) begin
                    st_nxt = ST_FETCH;
                end
            end
            ST_HALT: begin
                if (i_resume) begin
                    pc_nxt = spc_r;
                    st_nxt = ST_FETCH;
                end
            end
            default: st_nxt = ST_FETCH;
        endcase
        // interrupt events are never taken as a vector while running
        x_nxt = (o_mreq.we && o_mreq.addr == XPTR_ADDR) ? o_mreq.wdata : x_r;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= ST_FETCH;
            pc_r <= cod_ptr_s'(RESET_VECTOR);
            spc_r <= cod_ptr_s'(RESET_VECTOR);
            dec_r <= '{kind: K_NOP, amode: AM_INH, alu: ALU_ADD, cycles: CYC_ONE};
            flags_r <= '{z: 1'b0, c: 1'b0};
            acc_r <= ACC_RST;
            op_r <= 8'h00;
            mdata_r <= 8'h00;
            ea_r <= '0;
            ext_hi_r <= '0;
            x_r <= XPTR_RST;
            cnt_r <= 3'h0;
        end else begin
            st_r <= st_nxt;
            pc_r <= pc_nxt;
            spc_r <= spc_nxt;
            dec_r <= dec_nxt;
            flags_r <= flags_nxt;
            acc_r <= acc_nxt;
            op_r <= op_nxt;
            mdata_r <= mdata_nxt;
            ea_r <= ea_nxt;
            ext_hi_r <= ext_hi_nxt;
            x_r <= x_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ===========================================================
    // outputs
    // ===========================================================
    assign o_acc = acc_r;
    assign o_flags = flags_r;
    assign o_fetch_pointer = pc_r;
    assign o_saved_fetch_pointer = spc_r;
    assign o_core_clk_en = !(st_r == ST_WAIT || st_r == ST_STOP);

    always_comb begin
        case (st_r)
            ST_WAIT: o_mode = MODE_WAIT;
            ST_STOP: o_mode = MODE_STOP;
            ST_HALT: o_mode = MODE_HALT;
            default: o_mode = MODE_RUN;
        endcase
    end
endmodule // cod_core
`default_nettype wire

// File: sim/cod_mem_model.sv
// program memory model with same-cycle read for the op-decode slice
`default_nettype none
module cod_mem_model import cod_pkg::*; (
    input wire logic i_mclk,
    input wire cod_mreq_s i_mreq,
    output logic [7:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:16383];
    logic [7:0] last_r = 8'h00;
    // plain always: the bench preloads mem through the hierarchy
    always @(posedge i_mclk) begin
        if (i_mreq.we) begin
            mem[i_mreq.addr] <= i_mreq.wdata;
        end
        if (i_mreq.re) begin
            last_r <= o_rdata;
        end
    end
    // idle bus shows inverted data so a stale sample is caught
    always_comb begin
        o_rdata = i_mreq.re ? mem[i_mreq.addr] : ~last_r;
    end
endmodule // cod_mem_model
`default_nettype wire

// File: sim/cod_core_monitor.sv
// port checker for the op-decode slice
`default_nettype none
module cod_core_monitor import cod_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_rdata,
    input wire logic i_wake_evt,
    input wire logic i_halt_req,
    input wire logic i_resume,
    input wire cod_mreq_s o_mreq,
    input wire logic [7:0] o_acc,
    input wire cod_flags_s o_flags,
    input wire cod_ptr_s o_fetch_pointer,
    input wire cod_ptr_s o_saved_fetch_pointer,
    input wire logic o_core_clk_en,
    input wire cod_mode_e o_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    wire logic lp = (o_mode == MODE_WAIT) || (o_mode == MODE_STOP);
    wire logic bus = o_mreq.re || o_mreq.we;
    // ==========
    // low power
    // ==========
    property p_wait_in;
        (o_mode == MODE_WAIT && $past(o_mode) == MODE_RUN) |-> ($past(i_rdata) == OP_WAIT) && $past(o_mreq.re);
    endproperty
    a_wait_in: assert property (p_wait_in) else $error("wait entered without wait opcode");
    property p_stop_in;
        (o_mode == MODE_STOP && $past(o_mode) == MODE_RUN) |-> ($past(i_rdata) == OP_STOP) && $past(o_mreq.re);
    endproperty
    a_stop_in: assert property (p_stop_in) else $error("stop entered without stop opcode");
    property p_lp_gate;
        lp |-> !o_core_clk_en && !bus;
    endproperty
    a_lp_gate: assert property (p_lp_gate) else $error("activity during low power");
    property p_lp_hold;
        (lp && !i_wake_evt) |=> o_mode == $past(o_mode);
    endproperty
    a_lp_hold: assert property (p_lp_hold) else $error("left low power without event");
    property p_wake;
        (lp && i_wake_evt) |=> (o_mode == MODE_RUN) && o_mreq.re;
    endproperty
    a_wake: assert property (p_wake) else $error("event did not wake the core");
    // ==========
    // halt
    // ==========
    property p_halt_quiet;
        o_mode == MODE_HALT |-> !bus;
    endproperty
    a_halt_quiet: assert property (p_halt_quiet) else $error("bus activity while halted");
    property p_halt_pc;
        (o_mode == MODE_HALT && $past(o_mode) == MODE_HALT) |-> $stable(o_fetch_pointer);
    endproperty
    a_halt_pc: assert property (p_halt_pc) else $error("pointer moved while halted");
    property p_resume;
        (o_mode == MODE_HALT && i_resume && !i_halt_req) |-> ##[1:2] (o_mreq.re && o_mreq.addr == o_saved_fetch_pointer);
    endproperty
    a_resume: assert property (p_resume) else $error("resume missed saved pointer");
    // ==========
    // data path
    // ==========
    property p_redirect;
        bus |-> o_mreq.addr != XDATA_ADDR;
    endproperty
    a_redirect: assert property (p_redirect) else $error("pointer data cell reached the bus");
    property p_zero_flag;
        $changed(o_acc) |-> o_flags.z == (o_acc == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag disagrees with result");
    c_wait: cover property (o_mode == MODE_WAIT && i_wake_evt);
    c_halt: cover property (o_mode == MODE_HALT && i_resume);
    c_stop: cover property (o_mode == MODE_STOP);
endmodule // cod_core_monitor
bind cod_core cod_core_monitor mon_u (.i_mclk, .i_rst_b, .i_rdata, .i_wake_evt, .i_halt_req, .i_resume,
    .o_mreq, .o_acc, .o_flags, .o_fetch_pointer, .o_saved_fetch_pointer, .o_core_clk_en, .o_mode);
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the op-decode slice
`default_nettype none
module tb_top import cod_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] op, arg;
        logic [3:0] adv, cyc;
        logic [7:0] acc;
        logic [1:0] fl;
        logic ck;
    } cod_row_s;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_wake_evt = 1'b0;
    logic i_halt_req = 1'b0;
    logic i_resume = 1'b0;
    logic [7:0] i_rdata;
    cod_mreq_s o_mreq;
    logic [7:0] o_acc;
    cod_flags_s o_flags;
    cod_ptr_s o_fetch_pointer, o_saved_fetch_pointer;
    logic o_core_clk_en;
    cod_mode_e o_mode;
    int n_errors = 0;
    int n_tests = 0;
    cod_row_s rows [18];
    always #4 i_mclk = ~i_mclk;
    cod_core dut_u (.i_mclk, .i_rst_b, .i_rdata, .i_wake_evt, .i_halt_req, .i_resume, .o_mreq, .o_acc,
        .o_flags, .o_fetch_pointer, .o_saved_fetch_pointer, .o_core_clk_en, .o_mode);
    cod_mem_model mem_u (.i_mclk, .i_mreq(o_mreq), .o_rdata(i_rdata));
    // ==========
    // helpers
    // ==========
    task automatic tick();
        @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // bounded: a missing fetch shows up as a wrong count or address
    task automatic wait_fetch(input logic [13:0] a, output int n);
        n = 0;
        while (!(o_mreq.re === 1'b1 && o_mreq.addr === a) && n < 40) begin
            tick();
            n++;
        end
        // a fetch that never comes must not slip past a later loose check
        if (n >= 40) begin
            n_errors++;
            $display("[ERR] fetch addr expected %h seen %h", a, o_mreq.addr);
        end
    endtask
    task automatic wait_mode(input cod_mode_e m);
        for (int k = 0; k < 40 && o_mode !== m; k++) tick();
    endtask
    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin : watchdog
        repeat (5000) @(posedge i_mclk);
        n_errors++;
        print_verdict();
    end
    // ==========
    // main sequence
    // ==========
    initial begin : main
        logic [13:0] a, e;
        int n;
        for (int i = 0; i < 16384; i++) mem_u.mem[i] = 8'h00;
        mem_u.mem[14'h3ffd] = 8'hbc;
        mem_u.mem[14'h3ffe] = 8'h01;
        mem_u.mem[14'h05] = 8'h7f;
        mem_u.mem[14'h40] = 8'hf0;
        mem_u.mem[14'h50] = 8'h21;
        mem_u.mem[14'h13] = 8'h33;
        rows = '{
            '{8'hab, 8'h01, 4'h2, 4'h2, 8'h01, 2'b00, 1'b1},
            '{8'h65, 8'h00, 4'h1, 4'h3, 8'h80, 2'b00, 1'b1},
            '{8'hbb, 8'h40, 4'h2, 4'h3, 8'h70, 2'b01, 1'b1},
            '{8'ha9, 8'h8f, 4'h2, 4'h2, 8'h00, 2'b11, 1'b1},
            '{8'hb9, 8'h40, 4'h2, 4'h3, 8'hf1, 2'b00, 1'b1},
            '{8'h48, 8'h00, 4'h1, 4'h1, 8'he2, 2'b01, 1'b1},
            '{8'hab, 8'h1e, 4'h2, 4'h2, 8'h00, 2'b11, 1'b1},
            '{8'hab, 8'h50, 4'h2, 4'h2, 8'h50, 2'b00, 1'b1},
            '{8'hef, 8'h00, 4'h1, 4'h2, 8'h50, 2'b00, 1'b0},
            '{8'hbb, 8'h0e, 4'h2, 4'h3, 8'h71, 2'b00, 1'b1},
            '{8'h6e, 8'h00, 4'h1, 4'h3, 8'h92, 2'b00, 1'b1},
            '{8'hd3, 8'h00, 4'h1, 4'h2, 8'h33, 2'b00, 1'b1},
            '{8'h30, 8'h02, 4'h4, 4'h3, 8'h33, 2'b00, 1'b1},
            '{8'h35, 8'h05, 4'h2, 4'h3, 8'h33, 2'b00, 1'b1},
            '{8'h6f, 8'h00, 4'h1, 4'h3, 8'h83, 2'b00, 1'b1},
            '{8'h1e, 8'h13, 4'h2, 4'h5, 8'h83, 2'b00, 1'b1},
            '{8'h11, 8'h13, 4'h2, 4'h5, 8'h83, 2'b00, 1'b1},
            '{8'hd3, 8'h00, 4'h1, 4'h2, 8'hb2, 2'b00, 1'b1}};
        a = 14'h0100;
        foreach (rows[i]) begin
            mem_u.mem[a] = rows[i].op;
            mem_u.mem[a + 14'd1] = rows[i].arg;
            a = a + 14'(rows[i].adv);
        end
        e = a;
        mem_u.mem[e] = OP_WAIT;
        mem_u.mem[e + 14'd1] = OP_ADD_IMM;
        mem_u.mem[e + 14'd2] = 8'h05;
        mem_u.mem[e + 14'd3] = OP_BGND;
        mem_u.mem[e + 14'd5] = OP_STOP;
        repeat (16) tick();
        chk("pc upper", 16'h003f, o_fetch_pointer.upper);
        chk("pc lower", 16'h00fd, o_fetch_pointer.lower);
        chk("acc reset", ACC_RST, o_acc);
        @(posedge i_mclk);
        i_rst_b <= 1'b1;
        i_wake_evt <= 1'b1;
        #1;
        wait_fetch(14'h0100, n);
        chk("jump target", 14'h0100, o_mreq.addr);
        a = 14'h0100;
        foreach (rows[i]) begin
            wait_fetch(a + 14'(rows[i].adv), n);
            chk("cycles", rows[i].cyc, n[15:0]);
            chk("acc", rows[i].acc, o_acc);
            if (rows[i].ck) chk("flags", rows[i].fl, o_flags);
            a = a + 14'(rows[i].adv);
        end
        @(posedge i_mclk);
        i_wake_evt <= 1'b0;
        #1;
        wait_mode(MODE_WAIT);
        chk("clk en", 1'b0, o_core_clk_en);
        repeat (8) tick();
        chk("still waiting", MODE_WAIT, o_mode);
        @(posedge i_mclk);
        i_wake_evt <= 1'b1;
        #1;
        @(posedge i_mclk);
        i_wake_evt <= 1'b0;
        #1;
        chk("wake fetch", e + 14'd1, o_mreq.addr);
        chk("wake re", 1'b1, o_mreq.re);
        wait_fetch(e + 14'd3, n);
        chk("acc after wake", 8'hb7, o_acc);
        // first halt from the opcode, second from the request line
        for (int h = 0; h < 2; h++) begin
            wait_mode(MODE_HALT);
            chk("halt mode", MODE_HALT, o_mode);
            chk("saved pc", e + 14'd4, o_saved_fetch_pointer);
            @(posedge i_mclk);
            i_halt_req <= (h == 0);
            #1;
            @(posedge i_mclk);
            i_resume <= 1'b1;
            #1;
            @(posedge i_mclk);
            i_resume <= 1'b0;
            #1;
        end
        wait_fetch(e + 14'd4, n);
        chk("resume fetch", e + 14'd4, o_mreq.addr);
        wait_mode(MODE_STOP);
        chk("stop clk en", 1'b0, o_core_clk_en);
        repeat (4) tick();
        @(posedge i_mclk);
        i_rst_b <= 1'b0;
        #1;
        chk("reset wake", MODE_RUN, o_mode);
        chk("reset pc", RESET_VECTOR, o_fetch_pointer);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
